// file: hw/softkey.sv
// Software pushbutton/switch block with an AXI4-Lite register slave
`timescale 1ns/1ns
// Contract
// - Output set: enable high, switch on confirmed
// - Setting ignores momentary or latching action
// - Action selects momentary or latching
// - Enable rising edge resets output
// - Momentary clears output after one cycle
// - Confirmed switch off clears output
// - Non-retentive output loads start state
// - Action resets to momentary
module softkey (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic enable_pin,
  input wire logic power_fail_pin,
  output logic out_q,
  output logic scan_tick_q,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import softkey_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic enable_sync;
  logic fail_sync;
  logic action_q;
  logic retain_q;
  logic start_q;
  logic run_q;
  logic switch_q;
  logic [15:0] scan_div_q;
  logic [15:0] scan_cnt_q;
  logic enable_prev_q;
  logic fail_prev_q;
  logic on_pending_q;
  logic off_pending_q;
  logic init_pending_q;
  logic pulse_live_q;
  logic [3:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic do_write;
  logic [3:0] rd_addr;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic wr_switch;
  logic wr_switch_on;
  logic scan;
  logic power_back;
  logic enable_rise;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  level_sync enable_sync_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in(enable_pin),
    .sync_out(enable_sync)
  );

  level_sync fail_sync_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .async_in(power_fail_pin),
    .sync_out(fail_sync)
  );

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  // Address and data are taken in either order and held until both exist
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_hit = (awaddr_q == ctrl_offset) ||
                  (awaddr_q == switch_offset) ||
                  (awaddr_q == scan_offset);
  assign wr_switch = do_write && (awaddr_q == switch_offset) && wstrb_q[0];
  assign wr_switch_on = wdata_q[switch_on_bit];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      s_axi_awready <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end else begin
        s_axi_awready <= !aw_held_q && s_axi_awvalid;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end else begin
        s_axi_wready <= !w_held_q && s_axi_wvalid;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? resp_okay : resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      action_q <= action_reset;
      retain_q <= retain_reset;
      start_q <= start_reset;
      run_q <= run_reset;
      scan_div_q <= scan_cycles_reset;
    end else if (ce && do_write) begin
      if (awaddr_q == ctrl_offset && wstrb_q[0]) begin
        action_q <= wdata_q[ctrl_action_bit];
        retain_q <= wdata_q[ctrl_retain_bit];
        start_q <= wdata_q[ctrl_start_bit];
        run_q <= wdata_q[ctrl_run_bit];
      end
      if (awaddr_q == scan_offset) begin
        if (wstrb_q[0]) begin
          scan_div_q[7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          scan_div_q[15:8] <= wdata_q[15:8];
        end
      end
    end
  end

  // A write to the switch register is the operator's confirmation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_q <= switch_reset;
    end else if (ce && wr_switch) begin
      switch_q <= wr_switch_on;
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign rd_addr = {s_axi_araddr[3:2], 2'b00};

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (rd_addr)
      ctrl_offset: begin
        rd_word[ctrl_action_bit] = action_q;
        rd_word[ctrl_retain_bit] = retain_q;
        rd_word[ctrl_start_bit] = start_q;
        rd_word[ctrl_run_bit] = run_q;
      end
      switch_offset: begin
        rd_word[switch_on_bit] = switch_q;
      end
      status_offset: begin
        rd_word[status_out_bit] = out_q;
        rd_word[status_en_bit] = enable_sync;
        rd_word[status_pend_bit] = on_pending_q || off_pending_q;
        rd_word[status_fail_bit] = fail_sync;
      end
      scan_offset: begin
        rd_word[15:0] = scan_div_q;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? resp_okay : resp_slverr;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else begin
        s_axi_arready <= s_axi_arvalid;
      end
    end
  end

  // ****************************************
  // Program cycle timer
  // ****************************************
  // A divide value of zero behaves as one, so the scan never stalls
  assign scan = run_q && (scan_cnt_q == 16'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_cnt_q <= 16'h0000;
      scan_tick_q <= 1'b0;
    end else if (ce) begin
      scan_tick_q <= scan;
      if (!run_q || scan_cnt_q == 16'h0000) begin
        scan_cnt_q <= (scan_div_q == 16'h0000) ? 16'h0000
                                                : scan_div_q - 16'h0001;
      end else begin
        scan_cnt_q <= scan_cnt_q - 16'h0001;
      end
    end
  end

  // ****************************************
  // Confirmation and power events
  // ****************************************
  // Confirmations arrive at bus speed and are held until the next scan;
  // a new confirmation in the scan cycle wins over the consume
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      on_pending_q <= 1'b0;
      off_pending_q <= 1'b0;
    end else if (ce) begin
      if (wr_switch) begin
        on_pending_q <= wr_switch_on;
        off_pending_q <= !wr_switch_on;
      end else if (scan) begin
        on_pending_q <= 1'b0;
        off_pending_q <= 1'b0;
      end
    end
  end

  assign power_back = fail_prev_q && !fail_sync;

  // The first program start after reset and every power return load the start state into a non-retentive output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fail_prev_q <= 1'b0;
      init_pending_q <= 1'b1;
    end else if (ce) begin
      fail_prev_q <= fail_sync;
      if (power_back || (!run_q && init_pending_q)) begin
        init_pending_q <= 1'b1;
      end else if (scan) begin
        init_pending_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Output evaluation, once per program cycle
  // ****************************************
  assign enable_rise = enable_sync && !enable_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_prev_q <= 1'b0;
    end else if (ce && scan) begin
      enable_prev_q <= enable_sync;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= 1'b0;
      pulse_live_q <= 1'b0;
    end else if (ce && scan) begin
      pulse_live_q <= 1'b0;
      if (init_pending_q) begin
        if (!retain_q) begin
          out_q <= start_q;
        end
      end else if (enable_rise) begin
        out_q <= 1'b0;
      end else if (off_pending_q) begin
        out_q <= 1'b0;
      end else if (on_pending_q && enable_sync) begin
        // Action is not looked at when setting
        out_q <= 1'b1;
        pulse_live_q <= 1'b1;
      end else if (pulse_live_q && action_q == action_momentary) begin
        out_q <= 1'b0;
      end else begin
        out_q <= out_q;
      end
    end
  end

endmodule : softkey

// file: hw/softkey_pkg.sv
// Constants shared by the software pushbutton/switch block
package softkey_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] switch_offset = 4'h4;
  localparam logic [3:0] status_offset = 4'h8;
  localparam logic [3:0] scan_offset = 4'hc;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ctrl_action_bit = 0;
  localparam int ctrl_retain_bit = 1;
  localparam int ctrl_start_bit = 2;
  localparam int ctrl_run_bit = 3;
  localparam int switch_on_bit = 0;
  localparam int status_out_bit = 0;
  localparam int status_en_bit = 1;
  localparam int status_pend_bit = 2;
  localparam int status_fail_bit = 3;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic action_reset = 1'b0;
  localparam logic retain_reset = 1'b0;
  localparam logic start_reset = 1'b0;
  localparam logic run_reset = 1'b1;
  localparam logic switch_reset = 1'b0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int clk_period_ns = 50;
  localparam int scan_time_ns = 50000;
  localparam logic [15:0] scan_cycles_reset =
    16'(scan_time_ns / clk_period_ns);

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic action_momentary = 1'b0;
  localparam logic action_latching = 1'b1;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

endpackage : softkey_pkg

// file: hw/level_sync.sv
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ns
module level_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // The first flop feeds only the second one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : level_sync

// file: test/softkey_checker.sv
// Port assertions for the pushbutton/switch block
`timescale 1ns/1ns
module softkey_checker
  import softkey_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable_pin,
  input wire logic out_q,
  input wire logic scan_tick_q,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  logic [3:0] wa_q;
  logic [31:0] wd_q;
  logic action_q;
  logic done;
  logic sw_on;
  logic sw_off;
  logic latch;

  // ****************************************
  // Shadow of written settings
  // ****************************************
  // Only the live mode and the switch writes matter to the properties
  assign done = s_axi_bvalid && s_axi_bready && s_axi_bresp == resp_okay;
  assign sw_on = done && wa_q == switch_offset && wd_q[switch_on_bit];
  assign sw_off = done && wa_q == switch_offset && !wd_q[switch_on_bit];
  assign latch = action_q == action_latching;

  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      action_q <= action_momentary;
    end else if (done && wa_q == ctrl_offset) begin
      action_q <= wd_q[ctrl_action_bit];
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_clear: assert property ($rose(aresetn) |-> !out_q)
    else $error("output not clear after reset");
  chk_out_tick: assert property ($changed(out_q) |-> scan_tick_q)
    else $error("output moved outside a program cycle");
  chk_moment_end: assert property
    (scan_tick_q && !latch && $past(out_q) |-> !out_q)
    else $error("momentary output lasted over one cycle");
  chk_en_clear: assert property
    ($rose(enable_pin) ##1 enable_pin [*8] |-> !out_q)
    else $error("enable rise did not clear output");
  chk_off_clear: assert property (sw_off |-> ##6 !out_q)
    else $error("switch off did not clear output");
  chk_on_set: assert property
    (sw_on && enable_pin && $past(enable_pin, 8) |-> ##[1:6] out_q)
    else $error("switch on with enable did not set output");
  chk_latch_set: assert property
    (sw_on && enable_pin && latch |-> ##8 out_q)
    else $error("latching output not set");
  chk_latch_stay: assert property
    (latch && $rose(out_q) |-> out_q [*8])
    else $error("latching output dropped");
endmodule : softkey_checker

// file: test/tb_softkey.sv
// Self-checking bench for the pushbutton/switch block
`timescale 1ns/1ns
module tb_softkey;
  import softkey_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic enable_pin = 1'b0;
  logic power_fail_pin = 1'b0;
  logic ce = 1'b1;
  logic out_q, scan_tick_q;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  int err_count = 0;
  int samples_checked = 0;
  int n;

  always #25 aclk = ~aclk;

  softkey i_dut (.aclk, .aresetn, .ce, .enable_pin, .power_fail_pin,
    .out_q, .scan_tick_q, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  // ****************************************
  // Access tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, string w);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(w, s_axi_rdata, exp);
    check({w, " resp"}, 32'(s_axi_rresp), 32'(resp_okay));
  endtask : rd

  // A new divide value only takes effect once the running count expires
  task automatic wait_tick;
    n = 0;
    while (scan_tick_q !== 1'b1 && n < 1100) begin
      @(negedge aclk);
      n++;
    end
  endtask : wait_tick

  // Counts program-cycle ticks seen over c clock cycles into n
  task automatic count_ticks(input int c);
    n = 0;
    repeat (c) begin
      @(negedge aclk);
      if (scan_tick_q === 1'b1) n++;
    end
  endtask : count_ticks

  task automatic wait_n(input int c);
    repeat (c) @(negedge aclk);
  endtask : wait_n

  // Pins change after a clock edge, then settle through the synchroniser
  task automatic set_en(input logic v);
    @(posedge aclk);
    enable_pin <= v;
    wait_n(20);
  endtask : set_en

  task automatic power_cycle;
    @(posedge aclk);
    power_fail_pin <= 1'b1;
    wait_n(20);
    @(posedge aclk);
    power_fail_pin <= 1'b0;
    wait_n(20);
  endtask : power_cycle

  task automatic report_and_stop;
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ctrl_offset, 32'h8, "ctrl");
    rd(scan_offset, 32'(scan_cycles_reset), "scan");
    wr(scan_offset, 32'h4);
    wr(status_offset, 32'h0);
    check("ro resp", 32'(resp), 32'(resp_slverr));
    wait_tick();
    count_ticks(20);
    check("scan ticks", 32'(n), 32'h5);
    // Drop the clock enable just after a tick, so the frozen tick flop is low
    wait_tick();
    @(posedge aclk);
    ce <= 1'b0;
    count_ticks(20);
    check("frozen ticks", 32'(n), 32'h0);
    @(posedge aclk);
    ce <= 1'b1;
    wait_n(20);
    check("start off", 32'(out_q), 32'h0);
    set_en(1'b1);
    wr(switch_offset, 32'h1);
    n = 0;
    while (out_q !== 1'b1 && n < 50) begin
      @(negedge aclk);
      n++;
    end
    n = 0;
    while (out_q === 1'b1 && n < 50) begin
      @(negedge aclk);
      n++;
    end
    check("pulse len", 32'(n), 32'h4);
    set_en(1'b0);
    wr(switch_offset, 32'h1);
    wait_n(20);
    check("dropped", 32'(out_q), 32'h0);
    set_en(1'b1);
    wr(ctrl_offset, 32'h9);
    wr(switch_offset, 32'h1);
    wait_n(40);
    check("latched", 32'(out_q), 32'h1);
    wr(switch_offset, 32'h0);
    wait_n(10);
    check("off", 32'(out_q), 32'h0);
    wr(switch_offset, 32'h1);
    wait_n(10);
    set_en(1'b0);
    check("held", 32'(out_q), 32'h1);
    set_en(1'b1);
    check("rise clr", 32'(out_q), 32'h0);
    wr(ctrl_offset, 32'hd);
    power_cycle();
    check("start on", 32'(out_q), 32'h1);
    wr(switch_offset, 32'h0);
    wait_n(10);
    wr(ctrl_offset, 32'hf);
    power_cycle();
    check("retained", 32'(out_q), 32'h0);
    rd(status_offset, 32'h2, "status");
    report_and_stop();
  end

  // The first divide change waits out the reset count of a thousand
  // cycles, so a clean run takes about fourteen hundred cycles
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    report_and_stop();
  end
endmodule : tb_softkey

bind softkey softkey_checker i_chk (.aclk, .aresetn, .enable_pin, .out_q,
  .scan_tick_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready);
